// *** inc/stfs_pkg.sv ***
// ====================================================================
// Shared constants and types of the supply and thermal fault supervisor.
package stfs_pkg;

    // ================================================================
    // Timing: the figures in their own units and the derived cycle counts.
    localparam int unsigned CLK_PERIOD_NS        = 25;
    localparam int unsigned SHORT_FILTER_TIME_US = 2000;
    localparam int unsigned AUX_BLANK_TIME_US    = 4000;
    localparam int unsigned OV_FILTER_TIME_US    = 64;
    // Cooldown time is not fixed by the part; this default is a plain choice.
    localparam int unsigned COOLDOWN_TIME_US     = 1000;
    localparam int unsigned EXTEND_FACTOR        = 64;

    // Least times round up to whole cycles.
    localparam int unsigned SHORT_FILTER_CYC =
        (SHORT_FILTER_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned AUX_BLANK_CYC =
        (AUX_BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned COOLDOWN_CYC =
        (COOLDOWN_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] OV_FILTER_CYC =
        12'((OV_FILTER_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ================================================================
    // Event counter and status encodings.
    localparam logic [4:0] EVENT_LIMIT    = 5'h10;
    localparam logic [1:0] XCVR_FAIL_NONE = 2'h0;
    localparam logic [1:0] XCVR_FAIL_OT   = 2'h1;

    // ================================================================
    // Bit positions of the synchronised comparator vector.
    localparam int unsigned SYNC_W      = 9;
    localparam int unsigned IX_BAT_OK   = 0;
    localparam int unsigned IX_MAIN_RT  = 1;
    localparam int unsigned IX_AUX_UV   = 2;
    localparam int unsigned IX_XCVR_UV  = 3;
    localparam int unsigned IX_AUX_HOT  = 4;
    localparam int unsigned IX_XCVR_HOT = 5;
    localparam int unsigned IX_PREWARN  = 6;
    localparam int unsigned IX_CHIP_HOT = 7;
    localparam int unsigned IX_AUX_RAMP = 8;

    // ================================================================
    // Supervisor states.
    typedef enum logic [4:0] {
        S_RUN      = 5'h01,
        S_FS_SHORT = 5'h02,
        S_FS_HOT   = 5'h04,
        S_COOL     = 5'h08,
        S_RESTART  = 5'h10
    } stfs_state_t;

endpackage

// *** design/stfs_ov_filter.sv ***
`timescale 1ns/1ps
// ====================================================================
// Synchroniser and stability filter for the main supply overvoltage comparator.
module stfs_ov_filter
    import stfs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rawIn,
    output logic      filtOut
);

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        out;
        logic [11:0] cnt;
    } stfs_filt_t;

    stfs_filt_t q;
    stfs_filt_t d;

    // ================================================================
    // The output only follows a level that stayed put for the whole filter time.
    always_comb begin
        d    = q;
        d.s1 = rawIn;
        d.s2 = q.s1;
        if (q.s2 == q.out) begin
            d.cnt = 12'h000;
        end else if (q.cnt == OV_FILTER_CYC - 12'h001) begin // R20
            d.out = q.s2;
            d.cnt = 12'h000;
        end else begin
            d.cnt = q.cnt + 12'h001;
        end
    end

    // Registers the whole state copy.
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign filtOut = q.out;

    // ================================================================
    // Checks.
    property p_ov_filter;
        @(posedge clk) disable iff (rst)
        $changed(q.out) |-> $past(q.cnt) == OV_FILTER_CYC - 12'h001;
    endproperty
    a_ov_filter: assert property (p_ov_filter) else $error("ov filter too short"); // R20

endmodule

// *** design/stfs_supervisor.sv ***
`timescale 1ns/1ps
// Summary of operation
// [R1] Short detection only with battery above undervoltage.
// [R2] Main not up within filter: short fail-safe.
// [R3] Wake from bus, input or gpio leaves.
// [R4] Main low beyond filter time: same reaction.
// [R5] Aux undervoltage sets sticky flag, software clears.
// [R6] No aux undervoltage during blanking or ramps.
// [R7] Transceiver supply undervoltage sets sticky flag.
// [R8] Block overtemperature: switch off, set flag.
// [R9] Block thermal check only while block on.
// [R10] Aux overtemperature clears on-control, sets flag.
// [R11] Transceiver overtemperature: transmitter off, status 01.
// [R12] Thermal flags stay until software clears them.
// [R13] Prewarning flag, clearable after condition ends.
// [R14] Chip overtemperature: fail-safe, cooldown, restart, normal.
// [R15] Chip flag clear only normal, after end.
// [R16] With extend, count events; 64x cooldown.
// [R17] Sixteen events set safe latch, extended cooldown.
// [R18] Overtemperature during sleep entry means fail-safe.
// [R19] Threshold raise lifts thermal thresholds 10K.
// [R20] Overvoltage comparator filtered 64 us.
// [R21] Short filter 2 ms, also power-up blanking.
// [R22] Aux undervoltage blanking 4 ms after switch-on.
// [R23] All comparator inputs synchronised before use.
// [R24] Event counter clears with safe latch, reset.
module stfs_supervisor
    import stfs_pkg::*;
#(
    parameter int unsigned SHORT_FILT_CYC = SHORT_FILTER_CYC,
    parameter int unsigned AUX_BLANK_LEN  = AUX_BLANK_CYC,
    parameter int unsigned COOL_CYC       = COOLDOWN_CYC
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       batAboveUv,
    input  wire logic       mainAboveRt,
    input  wire logic       mainOvRaw,
    input  wire logic       auxBelowUv,
    input  wire logic       xcvrSupplyBelowUv,
    input  wire logic       auxHot,
    input  wire logic       xcvrHot,
    input  wire logic       mainPrewarnHot,
    input  wire logic       chipHot,
    input  wire logic       auxRamping,
    input  wire logic       auxOnWrite,
    input  wire logic       auxOnValue,
    input  wire logic       xcvrEnabled,
    input  wire logic       wakeBus,
    input  wire logic       wakeInput,
    input  wire logic       wakeGpio,
    input  wire logic       gpioWakeCfg,
    input  wire logic       sleepEntry,
    input  wire logic       delayExtendEn,
    input  wire logic       thresholdRaiseCfg,
    input  wire logic       clrMainShort,
    input  wire logic       clrFail,
    input  wire logic       clrAuxUv,
    input  wire logic       clrXcvrUv,
    input  wire logic       clrBlockOt,
    input  wire logic       clrAuxOt,
    input  wire logic       clrPrewarn,
    input  wire logic       clrChipOt,
    input  wire logic       clrSafeLatch,
    output logic            mainShortFlag,
    output logic            failFlag,
    output logic            failOutput,
    output logic            mainSupplyOn,
    output logic            auxSupplyOn,
    output logic            auxUvFlag,
    output logic            xcvrUvFlag,
    output logic            blockOvertempFlag,
    output logic            auxOvertempFlag,
    output logic            tempPrewarnFlag,
    output logic            chipOvertempFlag,
    output logic            overtempSafeLatch,
    output logic            txDisable,
    output logic [1:0]      xcvrFailStatus,
    output logic            failSafeReq,
    output logic            restartReq,
    output logic            normalReq,
    output logic            sleepAck,
    output logic            thresholdRaise,
    output logic            mainOvFiltered
);

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        stfs_state_t       st;
        logic [31:0]       shortCnt;
        logic [31:0]       blankCnt;
        logic [31:0]       coolCnt;
        logic [4:0]        evCnt;
        logic              chipHotPrev;
        logic              mainShort;
        logic              flagA;
        logic              failOut;
        logic              mainOn;
        logic              auxOn;
        logic              auxUv;
        logic              xcvrUv;
        logic              blockOt;
        logic              auxOt;
        logic              prewarn;
        logic              chipOt;
        logic              safeLatch;
        logic              txDis;
        logic [1:0]        xFail;
        logic              fsReq;
        logic              rstReq;
        logic              normReq;
        logic              sleepOk;
        logic              thrRaise;
    } stfs_sup_t;

    stfs_sup_t q;
    stfs_sup_t d;

    logic [SYNC_W-1:0] rawVec;
    logic              batOk;
    logic              mainUp;
    logic              auxLow;
    logic              xcvrLow;
    logic              auxHotS;
    logic              xcvrHotS;
    logic              prewarnS;
    logic              chipHotS;
    logic              auxRampS;
    logic              shortArm;
    logic              shortHit;
    logic              auxHotEv;
    logic              xHotEv;
    logic              chipEv;
    logic              wakeAny;
    logic [31:0]       coolLimit;

    // ================================================================
    // Comparator inputs: only the second synchroniser stage is read.
    assign rawVec = {auxRamping, chipHot, mainPrewarnHot, xcvrHot, auxHot,
                     xcvrSupplyBelowUv, auxBelowUv, mainAboveRt, batAboveUv};
    assign batOk    = q.s2[IX_BAT_OK];
    assign mainUp   = q.s2[IX_MAIN_RT];
    assign auxLow   = q.s2[IX_AUX_UV];
    assign xcvrLow  = q.s2[IX_XCVR_UV];
    assign auxHotS  = q.s2[IX_AUX_HOT];
    assign xcvrHotS = q.s2[IX_XCVR_HOT];
    assign prewarnS = q.s2[IX_PREWARN];
    assign chipHotS = q.s2[IX_CHIP_HOT];
    assign auxRampS = q.s2[IX_AUX_RAMP];

    // ================================================================
    // Derived events. Block heat only counts while that block is on.
    assign shortArm  = q.mainOn && batOk && !mainUp; // R1
    assign shortHit  = shortArm && (q.shortCnt == 32'(SHORT_FILT_CYC - 1)); // R21
    assign auxHotEv  = q.auxOn && auxHotS; // R9
    assign xHotEv    = xcvrEnabled && xcvrHotS; // R9
    assign chipEv    = chipHotS && !q.chipHotPrev;
    assign wakeAny   = wakeBus || wakeInput || (wakeGpio && gpioWakeCfg);
    // The extended wait is held for as long as the safe latch stands.
    assign coolLimit = q.safeLatch ? 32'(COOL_CYC * EXTEND_FACTOR) : 32'(COOL_CYC); // R16

    // ================================================================
    // Next-state logic. In every sticky flag the clear is applied first, so a
    // set in the same cycle wins and no event is lost.
    always_comb begin
        d             = q;
        d.s1          = rawVec; // R23
        d.s2          = q.s1; // R23
        d.chipHotPrev = chipHotS;
        d.fsReq       = 1'b0;
        d.rstReq      = 1'b0;
        d.normReq     = 1'b0;
        d.sleepOk     = 1'b0;
        d.thrRaise    = thresholdRaiseCfg; // R19

        // Short timer covers both the power-up blanking and a later collapse.
        if (!shortArm) begin
            d.shortCnt = 32'h0000_0000;
        end else if (!shortHit) begin
            d.shortCnt = q.shortCnt + 32'h0000_0001;
        end

        // Aux on-control: software writes it, overtemperature takes it away.
        if (auxOnWrite) begin
            d.auxOn = auxOnValue;
        end
        if (auxHotEv) begin
            d.auxOn = 1'b0; // R10
        end
        if (!q.auxOn && d.auxOn) begin
            d.blankCnt = 32'(AUX_BLANK_LEN); // R22
        end else if (q.blankCnt != 32'h0000_0000) begin
            d.blankCnt = q.blankCnt - 32'h0000_0001;
        end

        // Supply undervoltage flags.
        if (clrAuxUv) begin
            d.auxUv = 1'b0;
        end
        if (q.auxOn && auxLow && !auxRampS && q.blankCnt == 32'h0000_0000) begin // R6
            d.auxUv = 1'b1; // R5
        end
        if (clrXcvrUv) begin
            d.xcvrUv = 1'b0;
        end
        if (xcvrEnabled && xcvrLow) begin
            d.xcvrUv = 1'b1; // R7
        end

        // Per-block thermal shutdown; flags are held until cleared after cooling.
        if (clrBlockOt && !auxHotS && !xcvrHotS) begin // R12
            d.blockOt = 1'b0;
            d.xFail   = XCVR_FAIL_NONE;
        end
        if (clrAuxOt && !auxHotS) begin // R12
            d.auxOt = 1'b0;
        end
        if (auxHotEv || xHotEv) begin
            d.blockOt = 1'b1; // R8
        end
        if (auxHotEv) begin
            d.auxOt = 1'b1; // R10
        end
        // The transmitter comes back by itself once the block has cooled.
        d.txDis = xHotEv; // R11
        if (xHotEv) begin
            d.xFail = XCVR_FAIL_OT; // R11
        end

        // Prewarning.
        if (clrPrewarn && !prewarnS) begin
            d.prewarn = 1'b0; // R13
        end
        if (prewarnS) begin
            d.prewarn = 1'b1; // R13
        end

        // Chip overtemperature flag, event counter and safe latch.
        if (clrChipOt && q.st == S_RUN && !chipHotS) begin
            d.chipOt = 1'b0; // R15
        end
        if (chipHotS) begin
            d.chipOt = 1'b1; // R15
        end
        if (clrSafeLatch) begin
            d.safeLatch = 1'b0; // R24
            d.evCnt     = 5'h00; // R24
        end
        if (chipEv && delayExtendEn && d.evCnt != EVENT_LIMIT) begin
            d.evCnt = d.evCnt + 5'h01; // R16
            if (d.evCnt == EVENT_LIMIT) begin
                d.safeLatch = 1'b1; // R17
            end
        end

        // Fail flag and fail output are released together by software.
        if (clrMainShort) begin
            d.mainShort = 1'b0;
        end
        if (clrFail) begin
            d.flagA   = 1'b0;
            d.failOut = 1'b0;
        end

        // Supervisor state machine; a short wins over heat in the same cycle.
        unique case (q.st)
            S_RUN, S_RESTART: begin
                if (q.st == S_RESTART) begin
                    d.st      = S_RUN;
                    d.normReq = 1'b1; // R14
                end
                if (shortHit) begin
                    d.st        = S_FS_SHORT; // R2 R4
                    d.mainOn    = 1'b0;
                    d.mainShort = 1'b1;
                    d.flagA     = 1'b1;
                    d.failOut   = 1'b1;
                    d.fsReq     = 1'b1;
                    d.normReq   = 1'b0;
                end else if (chipHotS) begin
                    d.st      = S_FS_HOT; // R14 R18
                    d.mainOn  = 1'b0;
                    d.fsReq   = 1'b1;
                    d.normReq = 1'b0;
                end else if (sleepEntry && q.st == S_RUN) begin
                    d.sleepOk = 1'b1;
                end
            end
            S_FS_SHORT: begin
                if (wakeAny) begin
                    d.st     = S_RESTART; // R3
                    d.mainOn = 1'b1;
                    d.rstReq = 1'b1;
                end
            end
            S_FS_HOT: begin
                if (!chipHotS) begin
                    d.st      = S_COOL;
                    d.coolCnt = 32'h0000_0000;
                end
            end
            S_COOL: begin
                if (chipHotS) begin
                    d.st = S_FS_HOT;
                end else if (q.coolCnt + 32'h0000_0001 >= coolLimit) begin
                    d.st     = S_RESTART; // R14
                    d.mainOn = 1'b1;
                    d.rstReq = 1'b1;
                end else begin
                    d.coolCnt = q.coolCnt + 32'h0000_0001;
                end
            end
        endcase
    end

    // ================================================================
    // State register. After power-on the main supply is starting up.
    always_ff @(posedge clk) begin
        if (rst) begin
            q        <= '0;
            q.st     <= S_RUN;
            q.mainOn <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Overvoltage comparator path.
    stfs_ov_filter u_ovFilter (
        .clk     (clk),
        .rst     (rst),
        .rawIn   (mainOvRaw),
        .filtOut (mainOvFiltered)
    );

    // ================================================================
    // Outputs, each straight from the state register.
    assign mainShortFlag     = q.mainShort;
    assign failFlag          = q.flagA;
    assign failOutput        = q.failOut;
    assign mainSupplyOn      = q.mainOn;
    assign auxSupplyOn       = q.auxOn;
    assign auxUvFlag         = q.auxUv;
    assign xcvrUvFlag        = q.xcvrUv;
    assign blockOvertempFlag = q.blockOt;
    assign auxOvertempFlag   = q.auxOt;
    assign tempPrewarnFlag   = q.prewarn;
    assign chipOvertempFlag  = q.chipOt;
    assign overtempSafeLatch = q.safeLatch;
    assign txDisable         = q.txDis;
    assign xcvrFailStatus    = q.xFail;
    assign failSafeReq       = q.fsReq;
    assign restartReq        = q.rstReq;
    assign normalReq         = q.normReq;
    assign sleepAck          = q.sleepOk;
    assign thresholdRaise    = q.thrRaise;

    // ================================================================
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_short_gate;
        !batOk |=> q.shortCnt == 32'h0000_0000;
    endproperty
    a_short_gate: assert property (p_short_gate) else $error("short timer ran at low battery"); // R1

    property p_short_react;
        shortHit |=> q.st == S_FS_SHORT && !q.mainOn && q.mainShort && q.flagA && q.failOut;
    endproperty
    a_short_react: assert property (p_short_react) else $error("short reaction missing"); // R2

    property p_wake;
        q.st == S_FS_SHORT && wakeAny |=> q.st == S_RESTART && q.mainOn ##1 q.st == S_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not leave fail-safe"); // R3

    property p_aux_blank;
        q.blankCnt != 32'h0000_0000 && !q.auxUv |=> !q.auxUv;
    endproperty
    a_aux_blank: assert property (p_aux_blank) else $error("aux flag set while blanked"); // R6

    property p_aux_hot;
        auxHotEv |=> !q.auxOn && q.auxOt && q.blockOt;
    endproperty
    a_aux_hot: assert property (p_aux_hot) else $error("aux overtemperature reaction missing"); // R10

    property p_xcvr_hot;
        xHotEv |=> q.txDis && q.xFail == XCVR_FAIL_OT ##1 ($past(xHotEv) || !q.txDis);
    endproperty
    a_xcvr_hot: assert property (p_xcvr_hot) else $error("transmitter handling wrong"); // R11

    property p_prewarn_hold;
        prewarnS |=> q.prewarn;
    endproperty
    a_prewarn_hold: assert property (p_prewarn_hold) else $error("prewarn flag lost"); // R13

    property p_chip_hold;
        q.chipOt && q.st != S_RUN |=> q.chipOt;
    endproperty
    a_chip_hold: assert property (p_chip_hold) else $error("chip flag cleared outside normal"); // R15

    property p_safe_latch;
        chipEv && delayExtendEn && !clrSafeLatch && q.evCnt == 5'h0F
            |=> q.safeLatch && q.evCnt == EVENT_LIMIT;
    endproperty
    a_safe_latch: assert property (p_safe_latch) else $error("safe latch not set at 16"); // R17

    property p_sleep_hot;
        q.st == S_RUN && sleepEntry && chipHotS && !shortHit |=> !q.sleepOk && q.st == S_FS_HOT;
    endproperty
    a_sleep_hot: assert property (p_sleep_hot) else $error("sleep taken while hot"); // R18

    property p_latch_clear;
        clrSafeLatch && !chipEv |=> q.evCnt == 5'h00 && !q.safeLatch;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("counter not cleared"); // R24

    c_short:   cover property (q.st == S_RUN ##1 q.st == S_FS_SHORT);
    c_cool:    cover property (q.st == S_COOL ##1 q.st == S_RESTART ##1 q.st == S_RUN);
    c_latch:   cover property ($rose(q.safeLatch));
    c_aux_uv:  cover property ($rose(q.auxUv));

endmodule

// *** verification/stfs_mcu_model.sv ***
`timescale 1ns/1ps
// ====================================================================
// Software side: passes a clear request on as clear strobes, one cycle later.
module stfs_mcu_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [8:0] clrReq,
    output logic [8:0]      clrStrobe
);
    // Registered so every strobe starts just after an edge and lasts as long as its request.
    always_ff @(posedge clk) begin
        if (rst) begin
            clrStrobe <= 9'h000;
        end else begin
            clrStrobe <= clrReq;
        end
    end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
// ====================================================================
// Self-checking bench of the supervisor with shortened counts.
module tb_top;
    import stfs_pkg::*;
    logic clk, rst, batAboveUv, mainAboveRt, mainOvRaw, auxBelowUv, xcvrSupplyBelowUv;
    logic auxHot, xcvrHot, mainPrewarnHot, chipHot, auxRamping, auxOnWrite, auxOnValue;
    logic xcvrEnabled, wakeBus, wakeInput, wakeGpio, gpioWakeCfg, sleepEntry;
    logic delayExtendEn, thresholdRaiseCfg, mainShortFlag, failFlag, failOutput;
    logic mainSupplyOn, auxSupplyOn, auxUvFlag, xcvrUvFlag, blockOvertempFlag;
    logic auxOvertempFlag, tempPrewarnFlag, chipOvertempFlag, overtempSafeLatch, txDisable;
    logic [1:0] xcvrFailStatus;
    logic [8:0] clrReq, clr;
    logic [20:0] stat, expQ[$];
    logic thresholdRaise, mainOvFiltered, failSafeReq, restartReq, normalReq, sleepAck;
    logic ovHold = 1'b0;
    logic [3:0] seen;
    // Expected pulses seen, filter output, raise setting and transceiver flag.
    logic [6:0] xtra = 7'h00;
    int miscompares = 0, check_count = 0;
    logic [31:0] rs = 32'hEA15;
    event chkEv;
    // ====================================================================
    // Design, software model and clock.
    stfs_supervisor #(.SHORT_FILT_CYC(20), .AUX_BLANK_LEN(30), .COOL_CYC(10)) uut (
        .clk, .rst, .batAboveUv, .mainAboveRt, .mainOvRaw, .auxBelowUv, .xcvrSupplyBelowUv,
        .auxHot, .xcvrHot, .mainPrewarnHot, .chipHot, .auxRamping, .auxOnWrite, .auxOnValue,
        .xcvrEnabled, .wakeBus, .wakeInput, .wakeGpio, .gpioWakeCfg, .sleepEntry,
        .delayExtendEn, .thresholdRaiseCfg, .clrMainShort(clr[0]), .clrFail(clr[1]),
        .clrAuxUv(clr[2]), .clrXcvrUv(clr[3]), .clrBlockOt(clr[4]), .clrAuxOt(clr[5]),
        .clrPrewarn(clr[6]), .clrChipOt(clr[7]), .clrSafeLatch(clr[8]), .mainShortFlag,
        .failFlag, .failOutput, .mainSupplyOn, .auxSupplyOn, .auxUvFlag, .xcvrUvFlag,
        .blockOvertempFlag, .auxOvertempFlag, .tempPrewarnFlag, .chipOvertempFlag,
        .overtempSafeLatch, .txDisable, .xcvrFailStatus, .failSafeReq, .restartReq,
        .normalReq, .sleepAck, .thresholdRaise, .mainOvFiltered);
    stfs_mcu_model mcu (.clk, .rst, .clrReq, .clrStrobe(clr));
    assign stat = {seen, mainOvFiltered, thresholdRaise, xcvrUvFlag, failFlag,
                   overtempSafeLatch, mainShortFlag, failOutput, mainSupplyOn, auxSupplyOn,
                   auxOvertempFlag, blockOvertempFlag, txDisable, xcvrFailStatus,
                   chipOvertempFlag, auxUvFlag, tempPrewarnFlag};
    // Pulses last one cycle, so they are collected into sticky bits for the checks.
    always @(posedge clk) begin
        seen <= rst ? 4'h0 : (seen | {sleepAck, normalReq, restartReq, failSafeReq});
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ====================================================================
    // Helpers; every input change lands on a falling edge.
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic cy(input int n);
        repeat (n) begin
            @(negedge clk);
            rs = xs(rs);
            mainOvRaw = rs[0] | ovHold;
        end
    endtask
    task automatic chk(input logic [12:0] e);
        expQ.push_back({xtra, e[10], e}); // Fail flag and fail output move together.
        ->chkEv;
        #1;
    endtask
    task automatic sw(input logic [8:0] r);
        clrReq = r;
        cy(1);
        clrReq = 9'h000;
        cy(4);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Monitor: takes the oldest expectation whenever a result is presented.
    always @(chkEv) begin
        check_count++;
        if (stat !== expQ[0]) begin
            miscompares++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, expQ[0], stat);
        end
        void'(expQ.pop_front());
    end
    // Watchdog sized well above the whole sequence.
    initial begin
        #(25 * 20000);
        miscompares++;
        close_out();
    end
    // ====================================================================
    // Main sequence.
    initial begin
        {batAboveUv, mainAboveRt, xcvrEnabled, rst} = 4'hF;
        {mainOvRaw, auxBelowUv, xcvrSupplyBelowUv, auxHot, xcvrHot, mainPrewarnHot} = 6'h00;
        {chipHot, auxRamping, auxOnWrite, auxOnValue, wakeBus, wakeInput} = 6'h00;
        {wakeGpio, gpioWakeCfg, sleepEntry, delayExtendEn, thresholdRaiseCfg} = 5'h00;
        clrReq = 9'h000;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk(13'h0200);
        {auxOnWrite, auxOnValue, auxBelowUv} = 3'h7;
        cy(1);
        auxOnWrite = 1'b0;
        cy(10);
        chk(13'h0300);
        auxRamping = 1'b1;
        cy(30);
        chk(13'h0300);
        auxRamping = 1'b0;
        cy(5);
        chk(13'h0302);
        auxBelowUv = 1'b0;
        cy(3);
        sw(9'h004);
        chk(13'h0300);
        $display("aux undervoltage test done");
        auxHot = 1'b1;
        cy(5);
        sw(9'h030);
        chk(13'h02C0);
        auxHot = 1'b0;
        cy(5);
        chk(13'h02C0);
        sw(9'h030);
        chk(13'h0200);
        xcvrHot = 1'b1;
        cy(5);
        chk(13'h0268);
        xcvrHot = 1'b0;
        cy(5);
        chk(13'h0248);
        sw(9'h010);
        chk(13'h0200);
        $display("block thermal test done");
        chipHot = 1'b1;
        cy(5);
        sw(9'h080);
        xtra[3] = 1'b1;
        chk(13'h0004);
        cy(3 + rs[3:0]);
        chipHot = 1'b0;
        cy(20);
        xtra[5:4] = 2'h3;
        chk(13'h0204);
        sw(9'h080);
        chk(13'h0200);
        delayExtendEn = 1'b1;
        for (int i = 0; i < 16; i++) begin
            chipHot = 1'b1;
            cy(5);
            chipHot = 1'b0;
            cy(i < 15 ? 20 : 30);
        end
        chk(13'h1004);
        cy(700);
        chk(13'h1204);
        sw(9'h180);
        chk(13'h0200);
        $display("chip thermal test done");
        {batAboveUv, mainAboveRt} = 2'h0;
        cy(40);
        chk(13'h0200);
        {batAboveUv, wakeGpio} = 2'h3;
        cy(30);
        chk(13'h0C00);
        {wakeBus, wakeInput, wakeGpio, gpioWakeCfg} = rs[2] ? 4'h3 : (rs[1] ? 4'h8 : 4'h4);
        mainAboveRt = 1'b1;
        cy(1);
        {wakeBus, wakeInput, wakeGpio} = 3'h0;
        cy(4);
        chk(13'h0E00);
        sw(9'h003);
        chk(13'h0200);
        $display("short test done");
        {xcvrSupplyBelowUv, mainPrewarnHot, thresholdRaiseCfg} = 3'h7;
        cy(5);
        sw(9'h040);
        xtra[1:0] = 2'h3;
        chk(13'h0201);
        {xcvrSupplyBelowUv, mainPrewarnHot} = 2'h0;
        cy(3);
        sw(9'h048);
        xtra[0] = 1'b0;
        chk(13'h0200);
        {xcvrEnabled, xcvrSupplyBelowUv} = 2'h1;
        cy(5);
        chk(13'h0200);
        // Heat that the state machine sees in the same cycle as the sleep request must win over it.
        chipHot = 1'b1;
        cy(2);
        sleepEntry = 1'b1;
        cy(3);
        {chipHot, sleepEntry} = 2'h0;
        cy(20);
        sw(9'h080);
        chk(13'h0200);
        sleepEntry = 1'b1;
        cy(1);
        sleepEntry = 1'b0;
        cy(2);
        xtra[6] = 1'b1;
        chk(13'h0200);
        // A steady comparator level must be held out for the whole filter time.
        ovHold = 1'b1;
        cy(2500);
        chk(13'h0200);
        cy(80);
        xtra[2] = 1'b1;
        chk(13'h0200);
        $display("warning, sleep and filter test done");
        close_out();
    end
endmodule
